// ===== host_sync.sv
// host model driving the active-low restart pin of the sync block
// assumes the caller steps just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module host_sync (
	output var logic restart_n
);
	initial restart_n = 1'b1;
	// lowered to hold a filter reset or, in alternate mode, to end a channel
	// caller keeps it low for more than one clock
	task automatic drive_low();
		restart_n = 1'b0;
	endtask
	// raised only just after a rising edge
	task automatic drive_high();
		restart_n = 1'b1;
	endtask
endmodule // host_sync
`default_nettype wire

// ===== reg_sum.sv
// byte-wise checksum over the image of the monitored registers
// assumes the image is stable in the clk domain
`timescale 1ns/1ps
`default_nettype none
`include "sync_fault_consts.svh"

module reg_sum (
	input  wire logic                       clk,
	input  wire logic                       rst_b,
	input  wire logic [`MON_BYTES*8-1:0]    image,
	output logic      [7:0]                 sum_reg
);
	logic [7:0] part [0:`MON_BYTES];
	logic [7:0] sum_next;

	assign part[0] = `SUM_RESET;
	genvar i;
	generate
		for (i = 0; i < `MON_BYTES; i++) begin : g_fold
			assign part[i+1] = part[i] ^ image[i*8 +: 8];
		end
	endgenerate

	always_comb begin
		sum_next = part[`MON_BYTES];
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sum_reg <= `SUM_RESET;
		end else begin
			sum_reg <= sum_next;
		end
	end
endmodule // reg_sum
`default_nettype wire

// ===== sync_fault_consts.svh
// constants of the synchronisation and fault-flag block
// assumes inclusion by bare name from the package and modules
`ifndef SYNC_FAULT_CONSTS_SVH
`define SYNC_FAULT_CONSTS_SVH

`define STATUS_RESET      8'h80
`define STAT_RDY_BIT      7
`define STAT_CONV_BIT     6
`define STAT_WCRC_BIT     5
`define STAT_REGCHG_BIT   4
`define FPIN_OFF          2'h0
`define FPIN_INPUT        2'h1
`define FPIN_FAULT_OUT    2'h2
`define FPIN_GPO          2'h3
`define CODE_ALL_ONES     24'hffffff
`define CODE_ALL_ZEROS    24'h000000
`define DATA_RESET        24'h000000
`define SUM_RESET         8'h00
`define MON_BYTES         8
`define MIN_SYNC_LOW_CYC  1

`endif

// ===== sync_fault_ctrl.sv
// conversion synchronisation, fault flags and fault pin control
// assumes restart_n and all inputs are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "sync_fault_consts.svh"

// How it works
// - sync pin enable makes the restart pin a filter reset, settings kept
// - falling restart pin resets filter and modulator, held while low
// - after the pin rises, reset ends on the next clock edge
// - normal mode: rising pin starts a conversion, done signal falls after
// - alternate start mode bit turns the pin into a sequencing start
// - alternate: low pin finishes channel, selects next, waits for high
// - alternate: done falls and data updates without disturbing sampling
// - out of range result sets conversion fault; over/under gives rails
// - conversion fault clears only when the voltage fault is gone
// - write checksum fault set on bad write, cleared by status read
// - monitor enable checks registers, sets change fault when their XOR checksum changes
// - change fault clears only when monitor enable is written to zero
// - function 10 drives fault pin open drain with inverted fault OR
// - function 01 makes pin an input into conversion fault and level bit
// - function 00 disables the pin, 11 makes it a general output
// - as general output the pin follows the level bit
// - append enable adds status to each result, low bits give channel
// - drive boost bit raises output drive strength
module sync_fault_ctrl
	import sync_fault_pkg::*;
(
	input  wire logic                     clk,
	input  wire logic                     rst_b,
	input  wire logic                     sync_pin_en,
	input  wire logic                     alternate_start_mode,
	input  wire logic                     restart_n,
	input  wire conv_in_type              conv_in,
	input  wire logic                     data_read,
	input  wire logic                     status_read,
	input  wire logic                     wr_crc_bad,
	input  wire logic                     reg_monitor_en,
	input  wire logic [`MON_BYTES*8-1:0]  mon_image,
	input  wire logic [1:0]               fault_pin_func,
	input  wire logic                     fault_pin_level_wr,
	input  wire logic                     fault_pin_in,
	input  wire logic                     append_status_en,
	input  wire logic                     output_drive_boost,
	output logic                          filter_reset,
	output logic                          conv_start,
	output logic                          next_chan,
	output logic      [23:0]              data_reg,
	output logic                          ready_n,
	output logic      [7:0]               status_reg,
	output logic      [31:0]              result_word,
	output logic                          result_valid,
	output logic                          fault_pin_out,
	output logic                          fault_pin_oe,
	output logic                          fault_pin_level,
	output logic                          drive_boost
);
	core_state_type st_reg;
	core_state_type st_next;
	logic [7:0]     sum_reg;
	logic           fall;
	logic           rise;
	logic           take_done;
	logic [23:0]    code;
	logic [7:0]     status_now;
	logic           ext_fault;

	reg_sum reg_sum_inst (
		.clk    (clk),
		.rst_b  (rst_b),
		.image  (mon_image),
		.sum_reg(sum_reg)
	);

	// restart_d idles high after reset so a pin high at release never fakes a rise
	assign fall = sync_pin_en && st_reg.restart_d && !restart_n;
	assign rise = sync_pin_en && !st_reg.restart_d && restart_n;
	assign ext_fault = (fault_pin_func == `FPIN_INPUT) && !fault_pin_in;

	always_comb begin
		st_next = st_reg;
		st_next.restart_d = restart_n;
		st_next.conv_start = 1'b0;
		st_next.next_chan = 1'b0;
		st_next.result_valid = 1'b0;
		take_done = 1'b0;
		code = conv_in.code;
		status_now = `STATUS_RESET;

		// sequencing of the filter restart pin
		case (st_reg.seq)
		ST_RUN: begin
			take_done = conv_in.done;
			if (!sync_pin_en) begin
				st_next.alt_pending = 1'b0;
			end else if (fall && !alternate_start_mode) begin
				st_next.seq = ST_HELD;
				st_next.filter_reset = 1'b1;
			end else if (fall) begin
				st_next.alt_pending = 1'b1;
			end
			if (st_reg.alt_pending && conv_in.done) begin
				st_next.alt_pending = 1'b0;
				st_next.next_chan = 1'b1;
				st_next.seq = ST_PARK;
			end
		end
		ST_HELD: begin
			if (restart_n || !sync_pin_en) begin
				st_next.seq = ST_RUN;
				st_next.filter_reset = 1'b0;
				st_next.conv_start = 1'b1;
			end
		end
		ST_PARK: begin
			if (restart_n || !sync_pin_en) begin
				st_next.seq = ST_RUN;
				st_next.conv_start = 1'b1;
			end
		end
		default: begin
			st_next.seq = ST_RUN;
			st_next.filter_reset = 1'b0;
			st_next.alt_pending = 1'b0;
		end
		endcase

		// rail codes while the input is out of range
		if (conv_in.over_v) begin
			code = `CODE_ALL_ONES;
		end else if (conv_in.under_v) begin
			code = `CODE_ALL_ZEROS;
		end

		// fault flags: a set in the clearing cycle wins, except the change fault, where disable wins
		st_next.conv_fault = (st_reg.conv_fault
			&& (conv_in.over_v || conv_in.under_v))
			|| (take_done && conv_in.out_of_range)
			|| ext_fault;
		st_next.wcrc_fault = wr_crc_bad
			|| (st_reg.wcrc_fault && !status_read);
		// reference tracks the sum while off, so enabling starts clean
		if (!reg_monitor_en) begin
			st_next.regchg_fault = 1'b0;
			st_next.ref_sum = sum_reg;
		end else if (sum_reg != st_reg.ref_sum) begin
			st_next.regchg_fault = 1'b1;
		end

		if (take_done) begin
			st_next.data = code;
			st_next.chan = conv_in.chan;
			st_next.ready_n = 1'b0;
		end else if (data_read) begin
			st_next.ready_n = 1'b1;
		end

		status_now[`STAT_RDY_BIT] = st_next.ready_n;
		status_now[`STAT_CONV_BIT] = st_next.conv_fault;
		status_now[`STAT_WCRC_BIT] = st_next.wcrc_fault;
		status_now[`STAT_REGCHG_BIT] = st_next.regchg_fault;
		status_now[1:0] = st_next.chan;

		if (take_done) begin
			st_next.result_valid = 1'b1;
			if (append_status_en) begin
				st_next.result = {code, status_now};
			end else begin
				st_next.result = {8'h00, code};
			end
		end

		// fault pin function
		case (fault_pin_func)
		`FPIN_FAULT_OUT: begin
			st_next.fpin.out = 1'b0;
			st_next.fpin.oe = st_next.conv_fault || st_next.wcrc_fault
				|| st_next.regchg_fault;
			st_next.fpin.level = fault_pin_level_wr;
		end
		`FPIN_INPUT: begin
			st_next.fpin.out = 1'b0;
			st_next.fpin.oe = 1'b0;
			st_next.fpin.level = fault_pin_in;
		end
		`FPIN_GPO: begin
			st_next.fpin.out = fault_pin_level_wr;
			st_next.fpin.oe = 1'b1;
			st_next.fpin.level = fault_pin_level_wr;
		end
		default: begin
			st_next.fpin.out = 1'b0;
			st_next.fpin.oe = 1'b0;
			st_next.fpin.level = fault_pin_level_wr;
		end
		endcase

		st_next.drive_boost = output_drive_boost;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
			st_reg.seq <= ST_RUN;
			st_reg.restart_d <= 1'b1;
			st_reg.data <= `DATA_RESET;
			st_reg.ready_n <= 1'b1;
			st_reg.ref_sum <= `SUM_RESET;
			st_reg.result <= 32'h00000000;
		end else begin
			st_reg <= st_next;
		end
	end

	assign filter_reset = st_reg.filter_reset;
	assign conv_start = st_reg.conv_start;
	assign next_chan = st_reg.next_chan;
	assign data_reg = st_reg.data;
	assign ready_n = st_reg.ready_n;
	assign status_reg = {st_reg.ready_n, st_reg.conv_fault,
		st_reg.wcrc_fault, st_reg.regchg_fault, 2'b00, st_reg.chan};
	assign result_word = st_reg.result;
	assign result_valid = st_reg.result_valid;
	assign fault_pin_out = st_reg.fpin.out;
	assign fault_pin_oe = st_reg.fpin.oe;
	assign fault_pin_level = st_reg.fpin.level;
	assign drive_boost = st_reg.drive_boost;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	a_fall_holds_reset: assert property (
		fall && !alternate_start_mode && st_reg.seq == ST_RUN
		|=> filter_reset && st_reg.seq == ST_HELD)
		else $error("filter not reset on restart fall");
	a_reset_while_low: assert property (
		filter_reset && !restart_n && sync_pin_en |=> filter_reset)
		else $error("filter reset dropped while pin low");
	a_release_start: assert property (
		st_reg.seq == ST_HELD && restart_n |=> !filter_reset && conv_start)
		else $error("no release one cycle after pin rise");
	a_done_updates: assert property (
		conv_in.done && st_reg.seq == ST_RUN |=> !ready_n && result_valid)
		else $error("done not reported");
	a_alt_park: assert property (
		st_reg.alt_pending && conv_in.done && st_reg.seq == ST_RUN
		|=> next_chan && st_reg.seq == ST_PARK)
		else $error("next channel not selected");
	a_park_waits: assert property (
		st_reg.seq == ST_PARK && !restart_n && sync_pin_en
		|=> !conv_start)
		else $error("start while pin low");
	a_conv_fault_set: assert property (
		conv_in.done && conv_in.out_of_range && st_reg.seq == ST_RUN
		|=> status_reg[6])
		else $error("conversion fault not set");
	a_conv_fault_keep: assert property (
		status_reg[6] && (conv_in.over_v || conv_in.under_v) |=> status_reg[6])
		else $error("conversion fault cleared too early");
	a_wcrc_flag: assert property (
		wr_crc_bad |=> status_reg[5])
		else $error("write checksum fault not set");
	a_wcrc_clear: assert property (
		status_reg[5] && status_read && !wr_crc_bad |=> !status_reg[5])
		else $error("write checksum fault not cleared");
	a_regchg_clear: assert property (
		!reg_monitor_en |=> !status_reg[4])
		else $error("change fault survives disable");
	a_regchg_set: assert property (
		reg_monitor_en && $stable(reg_monitor_en) && sum_reg != st_reg.ref_sum
		|=> status_reg[4])
		else $error("register change missed");
	a_pin_fault_out: assert property (
		fault_pin_func == `FPIN_FAULT_OUT && $stable(fault_pin_func)
		|-> fault_pin_oe == (|status_reg[6:4]) && !fault_pin_out)
		else $error("fault pin not showing fault OR");
	a_pin_gpo: assert property (
		fault_pin_func == `FPIN_GPO |=> fault_pin_oe
		&& fault_pin_out == $past(fault_pin_level_wr))
		else $error("general output level wrong");
	a_append_chan: assert property (
		conv_in.done && append_status_en && st_reg.seq == ST_RUN
		|=> result_word[1:0] == $past(conv_in.chan))
		else $error("appended channel wrong");
	a_append_off: assert property (
		conv_in.done && !append_status_en && st_reg.seq == ST_RUN
		|=> result_word[31:24] == 8'h00)
		else $error("upper result byte not zero");
	a_sync_off_ignored: assert property (
		!sync_pin_en && st_reg.seq == ST_RUN |=> !filter_reset)
		else $error("filter reset while sync disabled");
	a_held_keeps_data: assert property (
		st_reg.seq == ST_HELD |=> $stable(data_reg))
		else $error("data changed while filter held");
	a_alt_no_reset: assert property (
		fall && alternate_start_mode && st_reg.seq == ST_RUN
		|=> !filter_reset && (st_reg.alt_pending || next_chan))
		else $error("alternate fall handled as reset");
	a_start_pulse: assert property (
		conv_start |=> !conv_start)
		else $error("start pulse longer than one cycle");
	a_rail_high: assert property (
		conv_in.done && conv_in.over_v && st_reg.seq == ST_RUN
		|=> data_reg == `CODE_ALL_ONES)
		else $error("overvoltage code not all ones");
	a_rail_low: assert property (
		conv_in.done && conv_in.under_v && !conv_in.over_v
		&& st_reg.seq == ST_RUN |=> data_reg == `CODE_ALL_ZEROS)
		else $error("undervoltage code not all zeros");
	a_wcrc_hold: assert property (
		status_reg[5] && !status_read |=> status_reg[5])
		else $error("write checksum fault lost without read");
	a_regchg_hold: assert property (
		status_reg[4] && reg_monitor_en |=> status_reg[4])
		else $error("change fault lost while enabled");
	a_conv_fault_ext: assert property (
		fault_pin_func == `FPIN_INPUT && !fault_pin_in |=> status_reg[6])
		else $error("external fault not in conversion flag");
	a_pin_level_in: assert property (
		fault_pin_func == `FPIN_INPUT
		|=> fault_pin_level == $past(fault_pin_in))
		else $error("pin level bit not following input");
	a_pin_off: assert property (
		fault_pin_func == `FPIN_OFF |=> !fault_pin_oe && !fault_pin_out)
		else $error("disabled fault pin driven");
	a_boost_copy: assert property (
		output_drive_boost |=> drive_boost)
		else $error("drive boost not applied");

	c_normal_sync: cover property (
		st_reg.seq == ST_HELD ##1 st_reg.seq == ST_RUN ##[1:50] !ready_n);
	c_alt_seq: cover property (next_chan ##[1:20] conv_start);
	c_regchg: cover property ($rose(status_reg[4]));
	c_fault_pin: cover property ($rose(fault_pin_oe) && !fault_pin_out);
	c_rail_code: cover property (conv_in.done && conv_in.over_v);
endmodule // sync_fault_ctrl
`default_nettype wire

// ===== sync_fault_ctrl_test.sv
// self-checking bench of the sync and fault-flag block
// assumes host_sync.sv and the block's package are compiled first
`timescale 1ns/1ps
`default_nettype none
module sync_fault_ctrl_test;
	import sync_fault_pkg::*;
	logic        clk = 1'b0, rst_b = 1'b0, sync_pin_en = 1'b0;
	logic        alternate_start_mode = 1'b0, restart_n, data_read = 1'b0;
	logic        status_read = 1'b0, wr_crc_bad = 1'b0, ext_level = 1'b1;
	logic        reg_monitor_en = 1'b0, fault_pin_level_wr = 1'b0;
	logic        append_status_en = 1'b0, output_drive_boost = 1'b0;
	logic [63:0] mon_image = 64'h0;
	logic [1:0]  fault_pin_func = 2'h0;
	conv_in_type conv_in = '0;
	logic        fault_pin_in, filter_reset, conv_start, next_chan, ready_n;
	logic        result_valid, fault_pin_out, fault_pin_oe;
	logic        fault_pin_level, drive_boost;
	logic [23:0] data_reg;
	logic [7:0]  status_reg;
	logic [31:0] result_word;
	int          num_errors = 0, comparisons = 0, cs_cnt = 0, nc_cnt = 0;
	int          c0, n0;

	always #10 clk = ~clk;
	// follows the block's output when enabled, else the external part drives it
	assign fault_pin_in = fault_pin_oe ? fault_pin_out : ext_level;

	always @(posedge clk) begin
		if (conv_start === 1'b1)
			cs_cnt++;
		if (next_chan === 1'b1)
			nc_cnt++;
	end

	host_sync host_sync_inst (.restart_n);

	sync_fault_ctrl sync_fault_ctrl_inst (.clk, .rst_b, .sync_pin_en,
		.alternate_start_mode, .restart_n, .conv_in, .data_read,
		.status_read, .wr_crc_bad, .reg_monitor_en, .mon_image,
		.fault_pin_func, .fault_pin_level_wr, .fault_pin_in,
		.append_status_en, .output_drive_boost, .filter_reset,
		.conv_start, .next_chan, .data_reg, .ready_n, .status_reg,
		.result_word, .result_valid, .fault_pin_out, .fault_pin_oe,
		.fault_pin_level, .drive_boost);

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic check(input string what, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conv(input logic [23:0] code, input logic [1:0] ch,
		input logic oor);
		conv_in.done = 1'b1;
		conv_in.code = code;
		conv_in.chan = ch;
		conv_in.out_of_range = oor;
		tick(1);
		conv_in.done = 1'b0;
		conv_in.out_of_range = 1'b0;
	endtask

	task automatic pulse_read(input logic st);
		data_read = ~st;
		status_read = st;
		tick(1);
		data_read = 1'b0;
		status_read = 1'b0;
		tick(1);
	endtask

	task automatic end_of_test();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		#1000000;
		num_errors++;
		end_of_test();
	end

	initial begin
		tick(16);
		rst_b = 1'b1;
		tick(1);
		check("status", 32'(status_reg), 32'h80);
		// restart pin ignored while sync is off
		host_sync_inst.drive_low();
		tick(2);
		check("reset_off", 32'(filter_reset), 32'h0);
		host_sync_inst.drive_high();
		sync_pin_en = 1'b1;
		tick(3);
		host_sync_inst.drive_low();
		tick(1);
		check("reset_on", 32'(filter_reset), 32'h1);
		tick(2);
		check("reset_held", 32'(filter_reset), 32'h1);
		host_sync_inst.drive_high();
		tick(1);
		check("reset_rel", 32'(filter_reset), 32'h0);
		check("start", 32'(conv_start), 32'h1);
		tick(1);
		check("start_end", 32'(conv_start), 32'h0);
		conv(24'h123456, 2'h2, 1'b0);
		check("data", 32'(data_reg), 32'h123456);
		check("done", 32'(ready_n), 32'h0);
		check("valid", 32'(result_valid), 32'h1);
		check("word", result_word, 32'h00123456);
		check("chan", 32'(status_reg[1:0]), 32'h2);
		pulse_read(1'b0);
		check("ready_back", 32'(ready_n), 32'h1);
		append_status_en = 1'b1;
		conv(24'h654321, 2'h1, 1'b0);
		check("app_data", 32'(result_word[31:8]), 32'h654321);
		check("app_chan", 32'(result_word[1:0]), 32'h1);
		append_status_en = 1'b0;
		pulse_read(1'b0);
		// over then under voltage: rail codes, flag kept until removed
		for (int i = 0; i < 2; i++) begin
			conv_in.over_v = (i == 0);
			conv_in.under_v = (i == 1);
			conv(24'h000001, 2'h0, 1'b1);
			check("rail", 32'(data_reg), i == 0 ? 32'hffffff : 32'h0);
			pulse_read(1'b0);
			check("conv_kept", 32'(status_reg[6]), 32'h1);
			conv_in.over_v = 1'b0;
			conv_in.under_v = 1'b0;
			tick(2);
			check("conv_clr", 32'(status_reg[6]), 32'h0);
		end
		wr_crc_bad = 1'b1;
		tick(1);
		wr_crc_bad = 1'b0;
		tick(3);
		check("crc_set", 32'(status_reg[5]), 32'h1);
		pulse_read(1'b1);
		check("crc_clr", 32'(status_reg[5]), 32'h0);
		mon_image = 64'h0123456789abcdef;
		tick(3);
		reg_monitor_en = 1'b1;
		tick(4);
		check("chg_quiet", 32'(status_reg[4]), 32'h0);
		mon_image[7:0] = 8'h00;
		tick(4);
		check("chg_set", 32'(status_reg[4]), 32'h1);
		reg_monitor_en = 1'b0;
		tick(2);
		check("chg_clr", 32'(status_reg[4]), 32'h0);
		// every pin function with a write checksum fault pending
		wr_crc_bad = 1'b1;
		tick(1);
		wr_crc_bad = 1'b0;
		ext_level = 1'b0;
		fault_pin_level_wr = 1'b1;
		for (int f = 0; f < 4; f++) begin
			fault_pin_func = 2'(f);
			tick(3);
			check("pin_oe", 32'(fault_pin_oe), 32'(f / 2));
			if (f == 1) begin
				check("pin_lvl", 32'(fault_pin_level), 32'h0);
				check("pin_conv", 32'(status_reg[6]), 32'h1);
			end
			if (f == 2)
				check("pin_fault", 32'(fault_pin_out), 32'h0);
			if (f == 3)
				check("pin_gpo", 32'(fault_pin_out), 32'h1);
		end
		fault_pin_func = 2'h2;
		ext_level = 1'b1;
		pulse_read(1'b1);
		check("pin_idle", 32'(fault_pin_oe), 32'h0);
		fault_pin_func = 2'h0;
		output_drive_boost = 1'b1;
		tick(2);
		check("boost", 32'(drive_boost), 32'h1);
		// alternate sequencing across channels 3 and next
		alternate_start_mode = 1'b1;
		tick(2);
		host_sync_inst.drive_low();
		tick(2);
		n0 = nc_cnt;
		c0 = cs_cnt;
		conv(24'h00abcd, 2'h3, 1'b0);
		tick(2);
		check("alt_next", 32'(nc_cnt - n0), 32'h1);
		check("alt_done", 32'(ready_n), 32'h0);
		check("alt_data", 32'(data_reg), 32'h00abcd);
		check("alt_wait", 32'(cs_cnt - c0), 32'h0);
		host_sync_inst.drive_high();
		for (int i = 0; i < 4 && cs_cnt == c0; i++)
			tick(1);
		check("alt_start", 32'(cs_cnt - c0), 32'h1);
		end_of_test();
	end
endmodule // sync_fault_ctrl_test
`default_nettype wire

// ===== sync_fault_pkg.sv
// types shared by the synchronisation and fault-flag block
// assumes sync_fault_consts.svh is on the include path
package sync_fault_pkg;
	`include "sync_fault_consts.svh"

	typedef enum logic [2:0] {
		ST_RUN  = 3'b001,
		ST_HELD = 3'b010,
		ST_PARK = 3'b100
	} seq_state_type;

	// one finished conversion from the modulator and filter
	typedef struct packed {
		logic        done;
		logic        out_of_range;
		logic        over_v;
		logic        under_v;
		logic [1:0]  chan;
		logic [23:0] code;
	} conv_in_type;

	typedef struct packed {
		logic out;
		logic oe;
		logic level;
	} fault_pin_type;

	typedef struct packed {
		seq_state_type seq;
		logic          restart_d;
		logic          filter_reset;
		logic          conv_start;
		logic          next_chan;
		logic          alt_pending;
		logic [23:0]   data;
		logic          ready_n;
		logic          conv_fault;
		logic          wcrc_fault;
		logic          regchg_fault;
		logic [1:0]    chan;
		logic [31:0]   result;
		logic          result_valid;
		logic [7:0]    ref_sum;
		fault_pin_type fpin;
		logic          drive_boost;
	} core_state_type;
endpackage
